// file: src/lfs_pkg.sv
// constants shared by the fault supervisor of the led backlight driver
// assumes one 20 mhz clock and detector inputs already synchronous to it
//
// How it works
// R1: enable low past shutdown count clears all
// R2: shut down keeps sinks off until enable
// R3: sync pin held low stops everything
// R4: cycle overcurrent blanks boost one cycle
// R5: secondary switch limit latches everything off
// R6: input current twice limit latches off
// R7: partial input overcurrent raises flag and input limit only
// R8: grace time expiry latches, clearing restores
// R9: host clears latch by long enable low
// R10: switch node overvoltage latches everything off
// R11: sink short at startup withholds soft-start
// R12: open sink found by raising output
// R13: current-set overcurrent stops boost and sinks
// R14: freq-set overcurrent stops all, flags, restarts
// R15: overvoltage pin stops boost while high
// R16: sink above short threshold leaves operation
// R17: overtemperature stops all, restarts without flag
// R18: undervoltage stops all and clears latches
// R19: startup blanking suppresses open detection
// R20: flag follows latching or latched faults, 1x input overcurrent and freq-set overcurrent
package lfs_pkg;

  // ==========================================================
  // clock and times
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_LOW_NS = 7000;
  // least time: round up
  localparam int SYNC_LOW_CYCLES = (SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHUTDOWN_CYCLES = 32750;
  localparam int GRACE_CYCLES = 10000;
  localparam int BLANK_CYCLES = 64;
  localparam int SOFTSTART_CYCLES = 32;

  // ==========================================================
  // widths and reset values
  localparam int LED_CH = 4;
  localparam int SHUT_W = 15;
  localparam int GRACE_W = 14;
  localparam int SYNC_W = 8;
  localparam int BLANK_W = 7;
  localparam logic RST_OFF = 1'b0;
  // fault pin output idles high so a released line never reads as flagged
  localparam logic RST_FLAG_N = 1'b1;

  typedef enum logic [1:0] {
    LFS_OFF,
    LFS_START,
    LFS_RUN
  } lfs_state_t;

endpackage

// file: src/lfs_count.sv
// held-level counter: done once run has stayed high for limit edges
// assumes run is synchronous to clock; counting restarts whenever run drops
module lfs_count #(
  parameter int W = 8,
  parameter int LIMIT = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic run,
  output logic done
);

  logic [W-1:0] cnt_ff;
  localparam logic [W-1:0] LIM = W'(LIMIT);

  // saturating count so done stays up while the level holds
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else if (!run) begin
      cnt_ff <= '0;
    end else if (cnt_ff != LIM) begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  assign done = run && (cnt_ff == LIM);

endmodule

// file: src/lfs_supervisor.sv
// fault supervisor: classifies detector events and steers boost,
// input disconnect, led sinks and the open-drain fault flag
// assumes detector levels and pins are synchronous to clock
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int SHUTDOWN_LIMIT = lfs_pkg::SHUTDOWN_CYCLES,
  parameter int GRACE_LIMIT = lfs_pkg::GRACE_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic pwm_en,
  input wire logic freq_set_sync_pin,
  input wire logic sw_cbc_det,
  input wire logic sw_cycle_start,
  input wire logic secondary_switch_limit_det,
  input wire logic in_oc_1x_det,
  input wire logic in_oc_2x_det,
  input wire logic switch_node_overvoltage_det,
  input wire logic [lfs_pkg::LED_CH-1:0] led_short_gnd_det,
  input wire logic [lfs_pkg::LED_CH-1:0] led_open_det,
  input wire logic [lfs_pkg::LED_CH-1:0] led_short_threshold_det,
  input wire logic current_set_pin_oc_det,
  input wire logic freq_set_sync_pin_oc_det,
  input wire logic overvoltage_sense_pin_det,
  input wire logic die_ot_det,
  input wire logic vin_uvlo_det,
  output logic boost_en_ff,
  output logic disc_en_ff,
  output logic disc_limit_ff,
  output logic [lfs_pkg::LED_CH-1:0] sink_en_ff,
  output logic softstart_go_ff,
  output logic raise_vout_ff,
  output logic low_power_ff,
  output logic fault_n_out_ff,
  output logic fault_n_oe_ff
);

  import lfs_pkg::*;

  lfs_state_t st_ff;
  lfs_state_t nxt_st;
  logic latch_ff;
  logic cbc_block_ff;
  logic [LED_CH-1:0] open_off_ff;
  logic sd_done;
  logic sync_done;
  logic grace_done;
  logic ss_done;
  logic blank_done;
  logic latch_set;
  logic restart;
  logic all_off;
  logic search;
  logic nxt_flag;

  // ==========================================================
  // timers
  lfs_count #(.W(SHUT_W), .LIMIT(SHUTDOWN_LIMIT)) u_shut (
    .clock(clock), .arst_n(arst_n), .run(!pwm_en), .done(sd_done)
  );
  lfs_count #(.W(SYNC_W), .LIMIT(SYNC_LOW_CYCLES)) u_sync (
    .clock(clock), .arst_n(arst_n), .run(!freq_set_sync_pin), .done(sync_done)
  );
  lfs_count #(.W(GRACE_W), .LIMIT(GRACE_LIMIT)) u_grace (
    .clock(clock), .arst_n(arst_n), .run(in_oc_1x_det && !latch_ff), .done(grace_done)
  );
  lfs_count #(.W(BLANK_W), .LIMIT(SOFTSTART_CYCLES)) u_ss (
    // soft-start restarts from zero whenever a fault holds the device off,
    // so a long restart fault cannot use up the ramp before it begins
    .clock(clock), .arst_n(arst_n),
    .run(st_ff == LFS_START && !all_off && !(|led_short_gnd_det)),
    .done(ss_done)
  );
  lfs_count #(.W(BLANK_W), .LIMIT(BLANK_CYCLES)) u_blank (
    .clock(clock), .arst_n(arst_n), .run(st_ff == LFS_RUN), .done(blank_done)
  );

  // ==========================================================
  // fault classes
  assign latch_set = secondary_switch_limit_det // R5
                   | in_oc_2x_det // R6
                   | grace_done // R8
                   | switch_node_overvoltage_det; // R10
  // auto-restart faults that take the device back through soft-start
  assign restart = die_ot_det | vin_uvlo_det | freq_set_sync_pin_oc_det | sync_done;
  assign all_off = latch_ff | latch_set | restart | (st_ff == LFS_OFF);
  // open-sink search only after startup blanking settles the output
  assign search = blank_done && |(led_open_det & ~open_off_ff); // R19

  // ==========================================================
  // operating state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      LFS_OFF: begin
        if (pwm_en) begin
          nxt_st = LFS_START; // R2
        end
      end
      LFS_START: begin
        if (ss_done && !all_off) begin
          nxt_st = LFS_RUN; // R11
        end
      end
      default: begin
        if (restart) begin
          nxt_st = LFS_START; // R14 R17
        end
      end
    endcase
    if (sd_done) begin
      nxt_st = LFS_OFF; // R1
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= LFS_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // latched faults: a new latching event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch_ff <= RST_OFF;
    end else if (latch_set) begin
      latch_ff <= 1'b1;
    end else if (sd_done || vin_uvlo_det) begin
      latch_ff <= 1'b0; // R1 R9 R18
    end
  end

  // boost blanked until the next switching cycle begins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cbc_block_ff <= RST_OFF;
    end else if (sw_cbc_det) begin
      cbc_block_ff <= 1'b1; // R4
    end else if (sw_cycle_start) begin
      cbc_block_ff <= 1'b0; // R4
    end
  end

  // ==========================================================
  // per-sink open detection and sink enables
  genvar gi;
  generate
    for (gi = 0; gi < LED_CH; gi++) begin : g_ch
      // a string still open when overvoltage trips is out of regulation
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          open_off_ff[gi] <= RST_OFF;
        end else if (st_ff != LFS_RUN) begin
          open_off_ff[gi] <= 1'b0;
        end else if (search && overvoltage_sense_pin_det && led_open_det[gi]) begin
          open_off_ff[gi] <= 1'b1; // R12
        end
      end

      // sinks follow dimming; shorted or open strings drop out alone
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          sink_en_ff[gi] <= RST_OFF;
        end else begin
          sink_en_ff[gi] <= !all_off && st_ff == LFS_RUN && pwm_en // R2
                            && !current_set_pin_oc_det // R13
                            && !open_off_ff[gi] // R12
                            && !led_short_threshold_det[gi]; // R16
        end
      end
    end
  endgenerate

  // ==========================================================
  // power stage controls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boost_en_ff <= RST_OFF;
      disc_en_ff <= RST_OFF;
      disc_limit_ff <= RST_OFF;
      softstart_go_ff <= RST_OFF;
      raise_vout_ff <= RST_OFF;
      low_power_ff <= RST_OFF;
    end else begin
      boost_en_ff <= !all_off && st_ff == LFS_RUN
                     && !(sw_cbc_det || cbc_block_ff) // R4
                     && !current_set_pin_oc_det // R13
                     && !overvoltage_sense_pin_det; // R15
      // disconnect stays closed through startup, 1x limiting and sense faults
      disc_en_ff <= !all_off; // R3 R5 R6 R10 R17 R18
      disc_limit_ff <= !all_off && in_oc_1x_det; // R7
      softstart_go_ff <= st_ff == LFS_START && !all_off && !(|led_short_gnd_det); // R11
      raise_vout_ff <= !all_off && search; // R12
      low_power_ff <= nxt_st == LFS_OFF;
    end
  end

  // ==========================================================
  // open-drain fault flag: pin pulled low while flagged
  assign nxt_flag = latch_ff | latch_set | freq_set_sync_pin_oc_det // R14
                  | (in_oc_1x_det && !latch_ff); // R7

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fault_n_oe_ff <= RST_OFF;
      fault_n_out_ff <= RST_FLAG_N;
    end else begin
      fault_n_oe_ff <= nxt_flag; // R20
      fault_n_out_ff <= !nxt_flag;
    end
  end

  // ==========================================================
  // checks
  property p_shut;
    @(posedge clock) disable iff (!arst_n)
      sd_done && !latch_set |=> st_ff == LFS_OFF && !latch_ff;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown did not clear"); // R1

  property p_off_sinks;
    @(posedge clock) disable iff (!arst_n)
      st_ff == LFS_OFF |=> sink_en_ff == '0;
  endproperty
  a_off_sinks: assert property (p_off_sinks) else $error("sink on in shutdown"); // R2

  property p_sync;
    @(posedge clock) disable iff (!arst_n)
      sync_done |=> !boost_en_ff && !disc_en_ff && sink_en_ff == '0;
  endproperty
  a_sync: assert property (p_sync) else $error("sync low did not stop"); // R3

  property p_cbc;
    @(posedge clock) disable iff (!arst_n)
      sw_cbc_det ##1 (sw_cycle_start && !sw_cbc_det) |=> !cbc_block_ff;
  endproperty
  a_cbc: assert property (p_cbc) else $error("boost blank over one cycle"); // R4

  property p_lim2;
    @(posedge clock) disable iff (!arst_n)
      secondary_switch_limit_det |=> latch_ff && fault_n_oe_ff && !disc_en_ff
        && !boost_en_ff && sink_en_ff == '0;
  endproperty
  a_lim2: assert property (p_lim2) else $error("switch limit not latched"); // R5

  property p_in2x;
    @(posedge clock) disable iff (!arst_n)
      in_oc_2x_det |=> latch_ff && fault_n_oe_ff && !disc_en_ff;
  endproperty
  a_in2x: assert property (p_in2x) else $error("2x input current not latched"); // R6

  property p_in1x;
    @(posedge clock) disable iff (!arst_n)
      in_oc_1x_det |=> fault_n_oe_ff;
  endproperty
  a_in1x: assert property (p_in1x) else $error("1x flag missing"); // R7

  property p_grace;
    @(posedge clock) disable iff (!arst_n)
      grace_done |=> latch_ff && !disc_en_ff;
  endproperty
  a_grace: assert property (p_grace) else $error("grace expiry not latched"); // R8

  property p_swov;
    @(posedge clock) disable iff (!arst_n)
      switch_node_overvoltage_det |=> latch_ff && !disc_en_ff && fault_n_oe_ff;
  endproperty
  a_swov: assert property (p_swov) else $error("open diode not latched"); // R10

  property p_current_set_pin;
    @(posedge clock) disable iff (!arst_n)
      current_set_pin_oc_det |=> !boost_en_ff && sink_en_ff == '0;
  endproperty
  a_current_set_pin: assert property (p_current_set_pin) else $error("current-set fault ignored"); // R13

  property p_ovp;
    @(posedge clock) disable iff (!arst_n)
      overvoltage_sense_pin_det |=> !boost_en_ff;
  endproperty
  a_ovp: assert property (p_ovp) else $error("boost on during overvoltage"); // R15

  property p_uvlo;
    @(posedge clock) disable iff (!arst_n)
      vin_uvlo_det && !latch_set |=> !latch_ff && !disc_en_ff;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("undervoltage kept latch"); // R18

  property p_flag;
    @(posedge clock) disable iff (!arst_n)
      latch_ff |=> fault_n_oe_ff && !fault_n_out_ff;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not raised while latched"); // R20

endmodule

// file: sim/lfs_host.sv
// host model: drives enable and sync pins, reads the open-drain fault line
// assumes the bench moves the requests just after a falling clock edge
module lfs_host (
  input wire logic en_req,
  input wire logic sync_req,
  input wire logic fault_n_out_ff,
  input wire logic fault_n_oe_ff,
  output logic pwm_en,
  output logic freq_set_sync_pin,
  output logic fault_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // pins follow the requests; long holds make shutdown and sync stop
  assign pwm_en = en_req;
  assign freq_set_sync_pin = sync_req;
  // line has a pull-up, so a released pin reads high, never stale
  assign fault_seen = ~(fault_n_oe_ff ? fault_n_out_ff : 1'h1);
endmodule

// file: sim/lfs_supervisor_tb.sv
// self-checking bench of the fault supervisor with a host model
// assumes short shutdown and grace counts set through parameters
module lfs_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lfs_pkg::*;
  localparam int SD = 50;
  localparam int GR = 40;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic en_req = 1'h0;
  logic sync_req = 1'h1;
  logic sw_cycle_start = 1'h0;
  logic in_oc_1x_det = 1'h0;
  logic vin_uvlo_det = 1'h0;
  logic [LED_CH-1:0] led_short_gnd_det = '0;
  logic [LED_CH-1:0] led_open_det = '0;
  logic [LED_CH-1:0] led_short_threshold_det = '0;
  logic [7:0] det = '0;
  logic sw_cbc_det, secondary_switch_limit_det, in_oc_2x_det, switch_node_overvoltage_det;
  logic current_set_pin_oc_det, freq_set_sync_pin_oc_det, overvoltage_sense_pin_det;
  logic die_ot_det, pwm_en, freq_set_sync_pin, fault_seen, boost_en_ff, disc_en_ff;
  logic disc_limit_ff, softstart_go_ff, raise_vout_ff, low_power_ff, fault_n_out_ff;
  logic fault_n_oe_ff;
  logic [LED_CH-1:0] sink_en_ff;
  int fails = 0;
  int comparisons = 0;
  int i;
  // ==========================================================
  // one detector per bit so a loop can walk the fault table
  assign {overvoltage_sense_pin_det, current_set_pin_oc_det, die_ot_det,
    freq_set_sync_pin_oc_det, sw_cbc_det, switch_node_overvoltage_det, in_oc_2x_det,
    secondary_switch_limit_det} = det;
  // 50 ns period
  always #25 clock = ~clock;
  lfs_supervisor #(.SHUTDOWN_LIMIT(SD), .GRACE_LIMIT(GR)) i_dut (
    .clock(clock), .arst_n(arst_n), .pwm_en(pwm_en), .freq_set_sync_pin(freq_set_sync_pin),
    .sw_cbc_det(sw_cbc_det), .sw_cycle_start(sw_cycle_start),
    .secondary_switch_limit_det(secondary_switch_limit_det),
    .in_oc_1x_det(in_oc_1x_det), .in_oc_2x_det(in_oc_2x_det),
    .switch_node_overvoltage_det(switch_node_overvoltage_det),
    .led_short_gnd_det(led_short_gnd_det), .led_open_det(led_open_det),
    .led_short_threshold_det(led_short_threshold_det),
    .current_set_pin_oc_det(current_set_pin_oc_det),
    .freq_set_sync_pin_oc_det(freq_set_sync_pin_oc_det),
    .overvoltage_sense_pin_det(overvoltage_sense_pin_det), .die_ot_det(die_ot_det),
    .vin_uvlo_det(vin_uvlo_det), .boost_en_ff(boost_en_ff), .disc_en_ff(disc_en_ff),
    .disc_limit_ff(disc_limit_ff), .sink_en_ff(sink_en_ff),
    .softstart_go_ff(softstart_go_ff), .raise_vout_ff(raise_vout_ff),
    .low_power_ff(low_power_ff), .fault_n_out_ff(fault_n_out_ff),
    .fault_n_oe_ff(fault_n_oe_ff)
  );
  lfs_host i_host (.en_req(en_req), .sync_req(sync_req), .fault_n_out_ff(fault_n_out_ff),
    .fault_n_oe_ff(fault_n_oe_ff), .pwm_en(pwm_en), .freq_set_sync_pin(freq_set_sync_pin),
    .fault_seen(fault_seen));
  // ==========================================================
  // helpers: boost, disconnect, sinks, flag expected per detector bit
  function automatic logic [3:0] want(input int k);
    case (k)
      0, 1, 2, 4: return 4'h1;
      3, 7: return 4'h6;
      5: return 4'h0;
      default: return 4'h4;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic look(input logic [3:0] e);
    chk({boost_en_ff, disc_en_ff, sink_en_ff, fault_seen}, {e[3], e[2], {4{e[1]}}, e[0]});
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // bounded wait for the boost to come back after soft-start
  task automatic wait_run;
    int n;
    for (n = 0; n < 300 && boost_en_ff !== 1'h1; n++) cyc(1);
    if (boost_en_ff !== 1'h1) begin
      fails++;
      $display("[ERR] %0t no restart", $time);
      print_verdict;
    end
  endtask
  // long enable low is the only way out of a latch besides undervoltage
  task automatic shut_down;
    en_req = 1'h0;
    cyc(SD + 3);
    chk({low_power_ff, sink_en_ff}, 5'h10);
    en_req = 1'h1;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hff4f7a31));
    i = $urandom_range(3, 0);
    cyc(6);
    arst_n = 1'h1;
    en_req = 1'h1;
    wait_run;
    for (int k = 0; k < 8; k++) begin
      cyc($urandom_range(9, 2));
      det[k] = 1'h1;
      cyc(1);
      look(want(k));
      det[k] = 1'h0;
      if (k < 3) begin
        cyc(4);
        look(want(k));
        if (k == 1) begin
          vin_uvlo_det = 1'h1;
          cyc(1);
          vin_uvlo_det = 1'h0;
        end else begin
          shut_down;
        end
      end
      sw_cycle_start = 1'h1;
      cyc(1);
      sw_cycle_start = 1'h0;
      wait_run;
      chk(fault_seen, 1'h0);
    end
    $display("test faults done");
    in_oc_1x_det = 1'h1;
    cyc(2);
    chk({fault_seen, boost_en_ff, disc_limit_ff}, 3'h7);
    cyc(GR / 2);
    in_oc_1x_det = 1'h0;
    cyc(2);
    chk({fault_seen, boost_en_ff}, 2'h1);
    in_oc_1x_det = 1'h1;
    cyc(GR + 3);
    in_oc_1x_det = 1'h0;
    cyc(1);
    look(4'h1);
    shut_down;
    wait_run;
    $display("test grace done");
    sync_req = 1'h0;
    cyc(SYNC_LOW_CYCLES - 2);
    chk(boost_en_ff, 1'h1);
    cyc(5);
    look(4'h0);
    sync_req = 1'h1;
    wait_run;
    led_short_threshold_det[i] = 1'h1;
    cyc(2);
    chk({boost_en_ff, disc_en_ff, sink_en_ff, fault_seen}, {2'h3, ~(4'h1 << i), 1'h0});
    led_short_threshold_det = '0;
    $display("test sync done");
    led_short_gnd_det[i] = 1'h1;
    shut_down;
    cyc(40);
    chk({softstart_go_ff, boost_en_ff, disc_en_ff, fault_seen}, 4'h2);
    led_short_gnd_det = '0;
    wait_run;
    led_open_det[i] = 1'h1;
    cyc(2);
    chk(raise_vout_ff, 1'h0);
    cyc(BLANK_CYCLES);
    chk(raise_vout_ff, 1'h1);
    det[7] = 1'h1;
    cyc(2);
    det[7] = 1'h0;
    cyc(2);
    chk({boost_en_ff, sink_en_ff[i], raise_vout_ff}, 3'h4);
    $display("test sinks done");
    print_verdict;
  end
endmodule
